// ---- design/alu_unit.sv ----
// Accumulator logical unit: formatted AND, stack AND, word OR, double OR.
`timescale 1ns/1ns
`default_nettype none

module alu_unit
  import alu_pkg::*;
#(
  parameter int DEPTH = ALU_STACK_DEPTH
)
(
  // Clock and synchronous reset.
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  // Request from the sequencer.
  input  wire logic        i_req_valid,
  input  wire alu_req_t    i_req,
  // Stack push and accumulator load from the sequencer.
  input  wire logic        i_acc_load,
  input  wire logic [31:0] i_acc_load_value,
  // Result and flags.
  output logic             o_done,
  output logic [31:0]      o_acc,
  output logic [31:0]      o_stack_top,
  output alu_flags_t       o_flags,
  output logic             o_negative_valid
);

  // Accumulator and stack storage; level 0 is the top.
  logic [31:0] acc;
  logic [31:0] stack [DEPTH];
  logic        done;
  alu_flags_t  flags;
  logic        neg_valid;

  // Mask that keeps the low count bits; a count of zero or of 32 and over keeps all.
  function automatic logic [31:0] count_mask(input logic [5:0] n);
    logic [31:0] m;
    m = 32'hffff_ffff;
    if ((n != 6'h00) && (n < 6'h20))
    begin
      m = ~(32'hffff_ffff << n);
    end
    return m;
  endfunction

  // Decoded operation results.
  wire alu_op_t     op       = i_req.op;
  // Bits above the count meet zero, so they clear in the accumulator.
  wire logic [31:0] fmt_mask = count_mask(i_req.bit_count);
  wire logic [31:0] and_fmt  = acc & i_req.operand & fmt_mask;
  wire logic [31:0] and_stk  = acc & stack[0];
  wire logic [15:0] or_word  = acc[15:0] | i_req.operand[15:0];
  wire logic [31:0] or_wfull = {acc[31:16], or_word};
  wire logic [31:0] or_dbl   = acc | i_req.operand;

  // Result selection for the accumulator.
  logic [31:0] next_acc;
  always_comb
  begin
    next_acc = acc;
    unique case (op)
      ALU_OP_FORMATTED_BIT_AND: next_acc = and_fmt;
      ALU_OP_STACK_AND:         next_acc = and_stk;
      ALU_OP_WORD_OR:           next_acc = or_wfull;
      ALU_OP_DOUBLE_WORD_OR:    next_acc = or_dbl;
    endcase
  end

  // Zero and negative conditions per operation.
  // Word OR judges zero on its 16-bit result only.
  wire logic zero16     = (or_word == 16'h0000);
  wire logic zero32     = (next_acc == 32'h0);
  wire logic next_zero  = (op == ALU_OP_WORD_OR) ? zero16 : zero32;
  wire logic next_neg   = next_acc[31];
  wire logic drives_neg = (op != ALU_OP_WORD_OR);

  // Accumulator, flags and done register.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      acc       <= ALU_ACC_RESET;
      flags     <= '0;
      neg_valid <= 1'b0;
      done      <= 1'b0;
    end
    else if (i_req_valid)
    begin
      acc                        <= next_acc;
      flags.zero_result_flag     <= next_zero;
      // Word OR leaves the negative flag as it was.
      if (drives_neg)
      begin
        flags.negative_result_flag <= next_neg;
      end
      neg_valid <= drives_neg;
      done      <= 1'b1;
    end
    else
    begin
      // A load pushes the old accumulator, as the sequencer's loads do.
      if (i_acc_load)
      begin
        acc <= i_acc_load_value;
      end
      done <= 1'b0;
    end
  end

  // Stack: pop on stack AND, push on accumulator load.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        stack[i] <= ALU_STK_RESET;
      end
    end
    else if (i_req_valid && (op == ALU_OP_STACK_AND))
    begin
      // Deeper levels move up one place; the bottom fills with zero.
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        stack[i] <= stack[i+1];
      end
      stack[DEPTH-1] <= ALU_STK_RESET;
    end
    else if (i_acc_load && !i_req_valid)
    begin
      // The oldest level falls off the bottom when the stack is full.
      stack[0] <= acc;
      for (int i = 1; i < DEPTH; i++)
      begin
        stack[i] <= stack[i-1];
      end
    end
  end

  // Outputs come straight from registers.
  assign o_done           = done;
  assign o_acc            = acc;
  assign o_stack_top      = stack[0];
  assign o_flags          = flags;
  assign o_negative_valid = neg_valid;

  // Checks next to the logic. Each looks one edge after the request, or after an
  // idle or load cycle for flag_hold_a, when the registered result and flags have settled.
  stack_and_res_a: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    i_req_valid && op == ALU_OP_STACK_AND
    |=> acc == ($past(acc) & $past(stack[0])))
    else $error("stack AND result wrong");
  stack_pop_a: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    i_req_valid && op == ALU_OP_STACK_AND |=> stack[0] == $past(stack[1]))
    else $error("stack did not pop");
  // The deepest levels matter too: a pop must move them and zero the bottom.
  stack_deep_a: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    i_req_valid && op == ALU_OP_STACK_AND
    |=> stack[DEPTH-2] == $past(stack[DEPTH-1])
        && stack[DEPTH-1] == ALU_STK_RESET)
    else $error("deep stack levels did not move up");
  stack_flags_a: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    i_req_valid && op == ALU_OP_STACK_AND
    |=> flags.zero_result_flag == (acc == 32'h0)
        && flags.negative_result_flag == acc[31])
    else $error("stack AND flags wrong");
  fmt_clear_a: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    i_req_valid && op == ALU_OP_FORMATTED_BIT_AND && i_req.bit_count == 6'h04
    |=> acc[31:4] == 28'h0)
    else $error("formatted AND upper bits kept");
  fmt_and_a: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    i_req_valid && op == ALU_OP_FORMATTED_BIT_AND
    |=> acc == ($past(acc) & $past(i_req.operand)
               & count_mask($past(i_req.bit_count))))
    else $error("formatted AND result wrong");
  fmt_flags_a: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    i_req_valid && op == ALU_OP_FORMATTED_BIT_AND
    |=> flags.zero_result_flag == (acc == 32'h0)
        && flags.negative_result_flag == acc[31])
    else $error("formatted AND flags wrong");
  word_or_res_a: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    i_req_valid && op == ALU_OP_WORD_OR
    |=> acc[15:0] == ($past(acc[15:0]) | $past(i_req.operand[15:0])))
    else $error("word OR low half wrong");
  word_or_a: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    i_req_valid && op == ALU_OP_WORD_OR
    |=> acc[31:16] == $past(acc[31:16])
        && o_flags.zero_result_flag == (acc[15:0] == 16'h0))
    else $error("word OR wrong");
  word_noneg_a: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    i_req_valid && op == ALU_OP_WORD_OR
    |=> !neg_valid && $stable(flags.negative_result_flag))
    else $error("word OR touched negative");
  dbl_flags_a: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    i_req_valid && op == ALU_OP_DOUBLE_WORD_OR
    |=> acc == ($past(acc) | $past(i_req.operand))
        && flags.negative_result_flag == acc[31]
        && flags.zero_result_flag == (acc == 32'h0))
    else $error("double OR wrong");
  // Loads and idle cycles must never disturb the flags.
  flag_hold_a: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    !i_req_valid |=> $stable(flags))
    else $error("flags changed without operation");

endmodule

`default_nettype wire

// ---- design/alu_pkg.sv ----
// Package with types and constants for the accumulator logic unit.
`default_nettype none
package alu_pkg;

  // Width of the accumulator and every stack level.
  localparam int ALU_WIDTH      = 32;
  // Width of a data memory word.
  localparam int ALU_WORD_WIDTH = 16;
  // Default depth of the accumulator stack.
  localparam int ALU_STACK_DEPTH = 8;
  // Value of the accumulator after reset.
  localparam logic [31:0] ALU_ACC_RESET = 32'h0000_0000;
  // Value of a stack level after reset.
  localparam logic [31:0] ALU_STK_RESET = 32'h0000_0000;
  // Cycles from a taken request to its answer.
  localparam int ALU_LATENCY = 1;

  // Operation codes issued by the sequencer.
  typedef enum logic [1:0]
  {
    ALU_OP_FORMATTED_BIT_AND = 2'b00,
    ALU_OP_STACK_AND         = 2'b01,
    ALU_OP_WORD_OR           = 2'b10,
    ALU_OP_DOUBLE_WORD_OR    = 2'b11
  } alu_op_t;

  // Request from the sequencer with its operands.
  typedef struct packed
  {
    alu_op_t     op;
    logic [31:0] operand;
    logic [5:0]  bit_count;
  } alu_req_t;

  // Status flags reported with each result.
  typedef struct packed
  {
    logic zero_result_flag;
    logic negative_result_flag;
  } alu_flags_t;

endpackage
`default_nettype wire

// ---- testbench/alu_seq_model.sv ----
// Sequencer model that issues operations and loads to the unit.
`timescale 1ns/1ns
`default_nettype none
module alu_seq_model
  import alu_pkg::*;
(
  // Clock.
  input  wire logic   i_ref_clk,
  // Request and load drives.
  output logic        o_req_valid,
  output alu_req_t    o_req,
  output logic        o_acc_load,
  output logic [31:0] o_acc_load_value
);
  // Idle at time zero.
  initial
  begin
    o_req_valid = 1'b0;
    o_acc_load = 1'b0;
    o_req = '0;
    o_acc_load_value = '0;
  end
  // One load or one operation, held for a single edge.
  task automatic send(input logic ld, input alu_op_t op,
                      input logic [31:0] v, input logic [5:0] n);
    @(posedge i_ref_clk) #1;
    o_req = '{op, v, n};
    o_acc_load_value = v;
    o_req_valid = !ld;
    o_acc_load = ld;
    @(posedge i_ref_clk) #1;
    o_req_valid = 1'b0;
    o_acc_load = 1'b0;
    // Stale operands are scrambled so nothing leans on them.
    o_req = ~o_req;
    o_acc_load_value = ~v;
  endtask
  // Load and operation in one cycle; the unit must take only the operation.
  task automatic clash(input alu_op_t op, input logic [31:0] v);
    @(posedge i_ref_clk) #1;
    o_req = '{op, v, 6'h00};
    o_acc_load_value = ~v;
    o_req_valid = 1'b1;
    o_acc_load = 1'b1;
    @(posedge i_ref_clk) #1;
    o_req_valid = 1'b0;
    o_acc_load = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb_accumulator_logic_and_or_unit.sv ----
// Self-checking bench for the accumulator logical unit.
`timescale 1ns/1ns
`default_nettype none
module tb_accumulator_logic_and_or_unit;
  import alu_pkg::*;
  logic        i_ref_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_req_valid, i_acc_load, o_done, o_negative_valid, z, ng;
  logic [31:0] i_acc_load_value, o_acc, o_stack_top, acc;
  logic [31:0] stk [0:7];
  alu_req_t    i_req;
  alu_flags_t  o_flags;
  int          fails = 0, n_tests = 0, cyc = 0;
  // Clock and timeout guard.
  always #25 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fails++;
      conclude();
    end
  end
  alu_seq_model alu_seq_model_i (.i_ref_clk(i_ref_clk),
    .o_req_valid(i_req_valid), .o_req(i_req), .o_acc_load(i_acc_load),
    .o_acc_load_value(i_acc_load_value));
  alu_unit alu_unit_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_req_valid(i_req_valid), .i_req(i_req), .i_acc_load(i_acc_load),
    .i_acc_load_value(i_acc_load_value), .o_done(o_done), .o_acc(o_acc),
    .o_stack_top(o_stack_top), .o_flags(o_flags),
    .o_negative_valid(o_negative_valid));
  // Compare and count.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Send one step, track the expected state, then judge the outputs.
  task automatic run(input logic ld, input alu_op_t op,
                     input logic [31:0] v, input logic [5:0] n);
    alu_seq_model_i.send(ld, op, v, n);
    if (ld)
    begin
      for (int k = 7; k > 0; k--) stk[k] = stk[k-1];
      stk[0] = acc;
      acc = v;
      check(o_done, 0);
      check(o_flags, {z, ng});
    end
    else
    begin
      if (op == ALU_OP_FORMATTED_BIT_AND)
        acc = acc & v & ((n == 0 || n >= 32) ? '1 : (32'h1 << n) - 1);
      if (op == ALU_OP_STACK_AND)
      begin
        acc = acc & stk[0];
        for (int k = 0; k < 7; k++) stk[k] = stk[k+1];
        stk[7] = '0;
      end
      if (op == ALU_OP_DOUBLE_WORD_OR)
        acc = acc | v;
      if (op == ALU_OP_WORD_OR)
        acc = acc | {16'h0, v[15:0]};
      z = (op == ALU_OP_WORD_OR) ? acc[15:0] == 0 : acc == 0;
      if (op != ALU_OP_WORD_OR) ng = acc[31];
      check(o_done, 1);
      check(o_flags, {z, ng});
      check(o_negative_valid, op != ALU_OP_WORD_OR);
    end
    check(o_acc, acc);
    check(o_stack_top, stk[0]);
  endtask
  // Loads push, then each stack AND pops one level.
  task automatic t_stack();
    run(1, ALU_OP_STACK_AND, 32'hf0f0_1234, 0);
    run(1, ALU_OP_STACK_AND, 32'h8ff0_00ff, 0);
    run(1, ALU_OP_STACK_AND, 32'hffff_0000, 0);
    repeat (3) run(0, ALU_OP_STACK_AND, 0, 0);
  endtask
  // Counts of 32, 4 and 1 bits, upper bits cleared.
  task automatic t_fand();
    run(1, ALU_OP_STACK_AND, 32'hffff_ffff, 0);
    run(0, ALU_OP_FORMATTED_BIT_AND, 32'h8000_000f, 6'h20);
    run(0, ALU_OP_FORMATTED_BIT_AND, 32'hffff_ffff, 6'h04);
    run(0, ALU_OP_FORMATTED_BIT_AND, 32'h0000_0000, 6'h01);
  endtask
  // Double OR flags, then word OR leaves the sign flag alone.
  task automatic t_or();
    run(1, ALU_OP_STACK_AND, 32'h0, 0);
    run(0, ALU_OP_DOUBLE_WORD_OR, 32'h0, 0);
    run(0, ALU_OP_DOUBLE_WORD_OR, 32'h3647_6a38, 0);
    run(1, ALU_OP_STACK_AND, 32'hffff_0000, 0);
    run(0, ALU_OP_DOUBLE_WORD_OR, 32'h8000_0000, 0);
    run(0, ALU_OP_WORD_OR, 32'h1234_0000, 0);
    run(0, ALU_OP_WORD_OR, 32'h1234_5678, 0);
  endtask
  // A load beside a double OR is refused: no push, only the OR lands.
  task automatic t_clash();
    run(1, ALU_OP_STACK_AND, 32'h0000_00f0, 0);
    alu_seq_model_i.clash(ALU_OP_DOUBLE_WORD_OR, 32'h0000_0f00);
    acc = acc | 32'h0000_0f00;
    z = (acc == 0);
    ng = acc[31];
    check(o_done, 1);
    check(o_acc, acc);
    check(o_stack_top, stk[0]);
    check(o_flags, {z, ng});
    @(posedge i_ref_clk) #1;
    check(o_done, 0);
    check(o_flags, {z, ng});
  endtask
  // Print counts and the verdict, then stop.
  task automatic conclude();
    $display("tests=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Reset for three cycles, then the scenarios.
  initial
  begin
    acc = '0;
    z = 1'b0;
    ng = 1'b0;
    foreach (stk[k]) stk[k] = '0;
    repeat (3) @(posedge i_ref_clk);
    #1 i_sys_rst = 1'b0;
    check(o_flags, 0);
    t_stack();
    t_fand();
    t_or();
    t_clash();
    conclude();
  end
endmodule
`default_nettype wire
